// ### include/sfp_defs.svh
// Summary of operation
// - While selected, the port shifts stored bytes out toward the host on its serial data output, most significant bit first.
// - The serial data output changes level only on falling edges of the host serial clock.
// - Each bit on the serial data input is captured at a rising edge of the host serial clock.
// - While chip select is low after a falling edge of chip select has been seen, the port is selected and active.
// - While chip select is high the port is deselected and its serial data output is released to high impedance.
// - After power up nothing starts until a falling edge of chip select has been seen; the host first clocks a byte with chip select held low.
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define SFP_BYTE_W      8
`define SFP_FIFO_DEPTH  16
`define SFP_CNT_W       3

// ----------------------------------------
// Bit counter values
// ----------------------------------------
`define SFP_CNT_ZERO    3'h0
`define SFP_CNT_LAST    3'h7

// ----------------------------------------
// Reset and fill values
// ----------------------------------------
`define SFP_TX_FILL     8'hFF
`define SFP_SDO_RST     1'h0
`define SFP_OE_N_RST    1'h1
`define SFP_PIN_RST     3'h0

`endif

// ### include/sfp_pkg.sv
`include "sfp_defs.svh"

package sfp_pkg;

	// Pins sampled from the link side
	typedef struct packed {
		logic sclk;
		logic csn;
		logic sdi;
	} sfp_pins_t;

	// Received byte stream
	typedef struct packed {
		logic                   valid;
		logic [`SFP_BYTE_W-1:0] data;
	} sfp_rx_t;

	typedef enum logic [1:0] {
		ST_WAIT_ARM,
		ST_IDLE,
		ST_ACTIVE
	} sfp_state_t;

endpackage

// ### logic/sfp_fifo.sv
`timescale 1ns/100ps
`default_nettype none

`include "sfp_defs.svh"

module sfp_fifo #(
	parameter int WIDTH = `SFP_BYTE_W,
	parameter int DEPTH = `SFP_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [CW-1:0]    count_ff;
	logic             full_ff;
	logic             empty_ff;
	logic [PW-1:0]    nxt_wr_ptr;
	logic [PW-1:0]    nxt_rd_ptr;
	logic [CW-1:0]    nxt_count;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// ----------------------------------------
	// Pointer and level bookkeeping
	// ----------------------------------------
	always_comb begin
		push       = in_valid & ~full_ff;
		pop        = out_ready & ~empty_ff;
		nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
		nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
		nxt_count  = count_ff;
		if (push && !pop) begin
			nxt_count = CW'(count_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_count = CW'(count_ff - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			full_ff   <= 1'b0;
			empty_ff  <= 1'b1;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
			full_ff   <= (nxt_count == CW'(DEPTH));
			empty_ff  <= (nxt_count == '0);
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	assign in_ready  = ~full_ff;
	assign out_valid = ~empty_ff;
	assign out_data  = mem[rd_ptr_ff];

endmodule // sfp_fifo

`default_nettype wire

// ### logic/sfp_port.sv
`timescale 1ns/100ps
`default_nettype none

`include "sfp_defs.svh"

module sfp_port
	import sfp_pkg::*;
#(
	parameter int FIFO_DEPTH = `SFP_FIFO_DEPTH
) (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   serial_clock_in,
	input  wire logic                   chip_select_n,
	input  wire logic                   serial_data_in,
	output logic                        serial_data_out,
	output logic                        serial_data_oe_n,
	input  wire logic                   tx_valid,
	input  wire logic [`SFP_BYTE_W-1:0] tx_data,
	output logic                        tx_ready,
	output logic                        rx_valid,
	output logic      [`SFP_BYTE_W-1:0] rx_data,
	output logic                        selected,
	output logic                        tx_underrun
);
	localparam logic [`SFP_BYTE_W-1:0] TX_FILL = `SFP_TX_FILL;

	// ----------------------------------------
	// Edge and shift helpers
	// ----------------------------------------
	function automatic logic edge_fall(input logic prev, input logic cur);
		edge_fall = prev & ~cur;
	endfunction

	function automatic logic edge_rise(input logic prev, input logic cur);
		edge_rise = ~prev & cur;
	endfunction

	function automatic logic [`SFP_BYTE_W-1:0] shift_in(input logic [`SFP_BYTE_W-1:0] sr,
	                                                     input logic                   lsb);
		shift_in = {sr[`SFP_BYTE_W-2:0], lsb};
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sfp_pins_t              pin_s1_ff;
	sfp_pins_t              pin_s2_ff;
	sfp_pins_t              pin_prev_ff;
	sfp_state_t             state_ff;
	sfp_state_t             nxt_state;
	logic [`SFP_CNT_W-1:0]  rx_cnt_ff;
	logic [`SFP_CNT_W-1:0]  nxt_rx_cnt;
	logic [`SFP_BYTE_W-1:0] rx_sr_ff;
	logic [`SFP_BYTE_W-1:0] nxt_rx_sr;
	sfp_rx_t                rx_ff;
	sfp_rx_t                nxt_rx;
	logic [`SFP_CNT_W-1:0]  tx_cnt_ff;
	logic [`SFP_CNT_W-1:0]  nxt_tx_cnt;
	logic [`SFP_BYTE_W-1:0] tx_sr_ff;
	logic [`SFP_BYTE_W-1:0] nxt_tx_sr;
	logic                   sdo_ff;
	logic                   nxt_sdo;
	logic                   oe_n_ff;
	logic                   nxt_oe_n;
	logic                   undr_ff;
	logic                   nxt_undr;
	logic                   sel_ff;
	logic                   nxt_sel;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic                   cs_fall;
	logic                   active;
	logic                   fifo_pop;
	logic                   fifo_valid;
	logic [`SFP_BYTE_W-1:0] fifo_data;
	logic                   fifo_in_ready;

	// ----------------------------------------
	// Pin synchronisers and edge finding
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_ff   <= `SFP_PIN_RST;
			pin_s2_ff   <= `SFP_PIN_RST;
			pin_prev_ff <= `SFP_PIN_RST;
		end else begin
			pin_s1_ff   <= '{sclk: serial_clock_in, csn: chip_select_n, sdi: serial_data_in};
			pin_s2_ff   <= pin_s1_ff;
			pin_prev_ff <= pin_s2_ff;
		end
	end

	// Reset value 0 keeps a select held low through reset from counting as a fall
	assign cs_fall   = edge_fall(pin_prev_ff.csn, pin_s2_ff.csn);
	assign sclk_rise = edge_rise(pin_prev_ff.sclk, pin_s2_ff.sclk);
	assign sclk_fall = edge_fall(pin_prev_ff.sclk, pin_s2_ff.sclk);
	assign active    = (state_ff == ST_ACTIVE) & ~pin_s2_ff.csn;

	// ----------------------------------------
	// Transmit byte buffer
	// ----------------------------------------
	sfp_fifo #(
		.WIDTH (`SFP_BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (tx_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (tx_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// ----------------------------------------
	// Next state and shift logic
	// ----------------------------------------
	always_comb begin
		nxt_state  = state_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_rx_sr  = rx_sr_ff;
		nxt_rx     = '{valid: 1'b0, data: rx_ff.data};
		nxt_tx_cnt = tx_cnt_ff;
		nxt_tx_sr  = tx_sr_ff;
		nxt_sdo    = sdo_ff;
		nxt_undr   = 1'b0;
		fifo_pop   = 1'b0;
		case (state_ff)
			ST_WAIT_ARM, ST_IDLE: begin
				if (cs_fall) begin
					nxt_state  = ST_ACTIVE;
					nxt_rx_cnt = `SFP_CNT_ZERO;
					nxt_tx_cnt = `SFP_CNT_ZERO;
				end
			end
			ST_ACTIVE: begin
				if (pin_s2_ff.csn) begin
					nxt_state = ST_IDLE;
				end else begin
					if (sclk_rise) begin
						nxt_rx_sr  = shift_in(rx_sr_ff, pin_s2_ff.sdi);
						nxt_rx_cnt = `SFP_CNT_W'(rx_cnt_ff + 1'b1);
						if (rx_cnt_ff == `SFP_CNT_LAST) begin
							nxt_rx = '{valid: 1'b1, data: nxt_rx_sr};
						end
					end
					if (sclk_fall) begin
						if (tx_cnt_ff == `SFP_CNT_ZERO) begin
							fifo_pop   = fifo_valid;
							nxt_undr   = ~fifo_valid;
							nxt_sdo    = fifo_valid ? fifo_data[`SFP_BYTE_W-1]
							                        : TX_FILL[`SFP_BYTE_W-1];
							nxt_tx_sr  = fifo_valid ? shift_in(fifo_data, 1'b0)
							                        : shift_in(TX_FILL, 1'b0);
							nxt_tx_cnt = `SFP_CNT_LAST;
						end else begin
							nxt_sdo    = tx_sr_ff[`SFP_BYTE_W-1];
							nxt_tx_sr  = shift_in(tx_sr_ff, 1'b0);
							nxt_tx_cnt = `SFP_CNT_W'(tx_cnt_ff - 1'b1);
						end
					end
				end
			end
			default: begin
				nxt_state = ST_WAIT_ARM;
			end
		endcase
		nxt_oe_n = (nxt_state != ST_ACTIVE);
		nxt_sel  = (nxt_state == ST_ACTIVE);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff  <= ST_WAIT_ARM;
			rx_cnt_ff <= `SFP_CNT_ZERO;
			rx_sr_ff  <= '0;
			rx_ff     <= '0;
			tx_cnt_ff <= `SFP_CNT_ZERO;
			tx_sr_ff  <= '0;
			sdo_ff    <= `SFP_SDO_RST;
			oe_n_ff   <= `SFP_OE_N_RST;
			undr_ff   <= 1'b0;
			sel_ff    <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_sr_ff  <= nxt_rx_sr;
			rx_ff     <= nxt_rx;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_sr_ff  <= nxt_tx_sr;
			sdo_ff    <= nxt_sdo;
			oe_n_ff   <= nxt_oe_n;
			undr_ff   <= nxt_undr;
			sel_ff    <= nxt_sel;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign serial_data_out  = sdo_ff;
	assign serial_data_oe_n = oe_n_ff;
	assign rx_valid         = rx_ff.valid;
	assign rx_data          = rx_ff.data;
	assign selected         = sel_ff;
	assign tx_underrun      = undr_ff;
	assign tx_ready         = fifo_in_ready;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_last_rise;
		active && sclk_rise && (rx_cnt_ff == `SFP_CNT_LAST);
	endsequence

	sequence s_load_fall;
		active && sclk_fall && (tx_cnt_ff == `SFP_CNT_ZERO) && fifo_valid;
	endsequence

	sequence s_empty_fall;
		active && sclk_fall && (tx_cnt_ff == `SFP_CNT_ZERO) && !fifo_valid;
	endsequence

	sequence s_bit_rise;
		active && sclk_rise;
	endsequence

	property p_rx_byte;
		s_last_rise |=> rx_valid && (rx_data == {$past(rx_sr_ff[6:0]), $past(pin_s2_ff.sdi)});
	endproperty
	a_rx_byte: assert property (p_rx_byte) else $error("received byte wrong");

	property p_rx_pulse;
		rx_valid |=> !rx_valid;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("rx_valid longer than one cycle");

	property p_sdo_on_fall;
		$changed(serial_data_out) |-> $past(active && sclk_fall);
	endproperty
	a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("data out moved off a falling edge");

	property p_tx_load;
		s_load_fall |=> (serial_data_out == $past(fifo_data[7])) && (tx_cnt_ff == `SFP_CNT_LAST);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("first bit of byte wrong");

	property p_tx_shift;
		active && sclk_fall && (tx_cnt_ff != `SFP_CNT_ZERO) |=> serial_data_out == $past(tx_sr_ff[7]);
	endproperty
	a_tx_shift: assert property (p_tx_shift) else $error("shifted bit wrong");

	property p_deselect;
		pin_s2_ff.csn |=> serial_data_oe_n ##1 serial_data_oe_n || !pin_s2_ff.csn;
	endproperty
	a_deselect: assert property (p_deselect) else $error("output driven while deselected");

	property p_select;
		cs_fall |=> (state_ff == ST_ACTIVE) && !serial_data_oe_n;
	endproperty
	a_select: assert property (p_select) else $error("select edge did not activate port");

	property p_wait_arm;
		(state_ff == ST_WAIT_ARM) && !cs_fall |=> (state_ff == ST_WAIT_ARM) && serial_data_oe_n;
	endproperty
	a_wait_arm: assert property (p_wait_arm) else $error("started before first select edge");

	property p_fill_byte;
		s_empty_fall |=> tx_underrun && (serial_data_out == TX_FILL[`SFP_BYTE_W-1]);
	endproperty
	a_fill_byte: assert property (p_fill_byte) else $error("fill bit not sent when empty");

	property p_undr_pulse;
		tx_underrun |=> !tx_underrun;
	endproperty
	a_undr_pulse: assert property (p_undr_pulse) else $error("underrun longer than one cycle");

	property p_rx_shift;
		s_bit_rise |=> (rx_sr_ff[0] == $past(pin_s2_ff.sdi))
			&& (rx_cnt_ff == `SFP_CNT_W'($past(rx_cnt_ff) + 1'b1));
	endproperty
	a_rx_shift: assert property (p_rx_shift) else $error("input bit not captured");

	property p_frame_start;
		cs_fall |=> (rx_cnt_ff == `SFP_CNT_ZERO) && (tx_cnt_ff == `SFP_CNT_ZERO);
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("bit counters not cleared");

	property p_quiet_deselected;
		(state_ff != ST_ACTIVE) && !cs_fall |=> $stable(rx_cnt_ff) && $stable(serial_data_out)
			&& !rx_valid;
	endproperty
	a_quiet_deselected: assert property (p_quiet_deselected) else $error("link moved unselected");

	property p_tx_hold;
		active && !sclk_fall |=> $stable(tx_cnt_ff) && $stable(tx_sr_ff);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmit state moved off a fall");

endmodule // sfp_port

`default_nettype wire

// ### logic/sfp_port_unused_placeholder_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### verification/sfp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module sfp_host_model (
	input  wire logic clk,
	output logic      serial_clock_in,
	output logic      chip_select_n,
	output logic      serial_data_in,
	input  wire logic serial_data_wire
);
	// ----------------------------------------
	// Pin levels from power up
	// ----------------------------------------
	initial begin
		serial_clock_in = 1'b1;
		chip_select_n   = 1'b0;
		serial_data_in  = 1'b0;
	end

	// ----------------------------------------
	// Framing
	// ----------------------------------------
	// Pins move on rising clk edges only
	task automatic select_dev();
		chip_select_n <= 1'b0;
		repeat (12) @(posedge clk);
	endtask

	task automatic deselect_dev();
		repeat (12) @(posedge clk);
		chip_select_n  <= 1'b1;
		// Data line leaves its last bit once the frame ends
		serial_data_in <= ~serial_data_in;
		repeat (12) @(posedge clk);
	endtask

	// ----------------------------------------
	// Bit transfer, 10 clk per serial clock, clock left high after each bit
	// ----------------------------------------
	task automatic shift_bits(input logic [7:0] mosi, input int nbits, output logic [7:0] miso);
		miso = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			serial_clock_in <= 1'b0;
			serial_data_in  <= mosi[7-i];
			repeat (5) @(posedge clk);
			serial_clock_in <= 1'b1;
			miso = {miso[6:0], serial_data_wire};
			repeat (5) @(posedge clk);
		end
	endtask
endmodule // sfp_host_model

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       clk;
	logic       rst_b;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       serial_clock_in;
	logic       chip_select_n;
	logic       serial_data_in;
	logic       serial_data_out;
	logic       serial_data_oe_n;
	logic       tx_ready;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       selected;
	logic       tx_underrun;
	logic       sdo_q;
	logic [7:0] miso;
	logic [7:0] rxq[$];
	int         fail_count;
	int         samples_checked;
	int         cycle_count;
	int         under_count;
	wire        serial_data_wire = serial_data_oe_n ? 1'bz : serial_data_out;

	sfp_port #(.FIFO_DEPTH(16)) uut (.clk(clk), .rst_b(rst_b), .serial_clock_in(serial_clock_in),
		.chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .selected(selected), .tx_underrun(tx_underrun));

	sfp_host_model host (.clk(clk), .serial_clock_in(serial_clock_in),
		.chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in), .serial_data_wire(serial_data_wire));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("TB: counts fail=%0d checked=%0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic settle();
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------
	// Monitors and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cycle_count++;
		if (rx_valid === 1'b1)
			rxq.push_back(rx_data);
		if (tx_underrun === 1'b1)
			under_count++;
		if (serial_data_oe_n === 1'b0 && serial_clock_in === 1'b1 && serial_data_out !== sdo_q) begin
			fail_count++;
			$display("Error at %0t: data moved on high clock %h %h", $time, serial_data_out, sdo_q);
		end
		sdo_q = serial_data_out;
		if (cycle_count == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check({7'h00, serial_data_oe_n}, 8'h01);
		check({7'h00, selected}, 8'h00);
		check({7'h00, tx_ready}, 8'h01);
	endtask

	task automatic t_prearm();
		host.shift_bits(8'h5A, 8, miso);
		settle();
		check(8'(rxq.size()), 8'h00);
		check({7'h00, serial_data_oe_n}, 8'h01);
	endtask

	task automatic t_idle_clock();
		host.deselect_dev();
		host.shift_bits(8'h3C, 8, miso);
		settle();
		check(8'(rxq.size()), 8'h00);
		check({7'h00, serial_data_oe_n}, 8'h01);
	endtask

	task automatic t_fill();
		@(posedge clk);
		for (int i = 0; i < 16; i++) begin
			tx_valid <= 1'b1;
			tx_data <= 8'hC0 + i[7:0];
			@(posedge clk);
		end
		tx_data <= 8'hAA;
		repeat (3) @(posedge clk);
		tx_valid <= 1'b0;
		@(posedge clk);
		check({7'h00, tx_ready}, 8'h00);
	endtask

	task automatic t_frame();
		host.select_dev();
		check({7'h00, serial_data_oe_n}, 8'h00);
		check({7'h00, selected}, 8'h01);
		for (int i = 0; i < 17; i++) begin
			host.shift_bits(8'h30 + i[7:0], 8, miso);
			check(miso, (i < 16) ? 8'hC0 + i[7:0] : 8'hFF);
		end
		host.deselect_dev();
		settle();
		check({7'h00, serial_data_oe_n}, 8'h01);
		check(8'(rxq.size()), 8'h11);
		for (int i = 0; i < 17; i++)
			check(rxq[i], 8'h30 + i[7:0]);
		check(8'(under_count), 8'h01);
		rxq.delete();
	endtask

	task automatic t_partial();
		host.select_dev();
		host.shift_bits(8'hF0, 4, miso);
		host.deselect_dev();
		host.select_dev();
		host.shift_bits(8'h96, 8, miso);
		check(miso, 8'hFF);
		host.deselect_dev();
		settle();
		check(8'(rxq.size()), 8'h01);
		check(rxq[0], 8'h96);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_prearm();
		t_idle_clock();
		t_fill();
		t_frame();
		t_partial();
		tally_and_finish();
	end
endmodule // tb_top

`default_nettype wire
